// *** fcc_host.sv ***
// Contract
// R01: Address one megabyte, byte-wide data path.
// R02: Sixteen 64 KB blocks, each erased alone.
// R03: Erase clears one block, long wait.
// R04: During suspend, read other blocks only.
// R05: Setup then confirm write, back to back.
// R06: Device sequences itself; host only waits.
// R07: Program one byte per write operation.
// R08: Status register gives busy and result.
// R09: Ready/busy low while operation runs.
// R10: Ready/busy high when idle or suspended.
// R11: Chip select and power-down high: standby.
// R12: Power-down low blocks every array change.
// R13: Wait 400 ns before reading after wake.
// R14: Wait 1 us before command writes.
// R15: Power-down low aborts and clears status.
// R16: Wake returns device to read-array mode.
// R17: Address and data latched on strobe rise.
// R18: Low programming supply refuses array changes.
`timescale 1ns/1ps
`default_nettype none
module fcc_host #(
   parameter logic [7:0] CMD_READ_ARRAY = 8'h01,
   parameter logic [7:0] CMD_READ_STATUS = 8'h02,
   parameter logic [7:0] CMD_CLEAR_STATUS = 8'h03,
   parameter logic [7:0] CMD_ERASE_SETUP = 8'h04,
   parameter logic [7:0] CMD_ERASE_CONFIRM = 8'h05,
   parameter logic [7:0] CMD_SUSPEND = 8'h06,
   parameter logic [7:0] CMD_RESUME = 8'h07,
   parameter logic [7:0] CMD_WRITE_SETUP = 8'h08,
   parameter logic [15:0] WE_CYC = 16'h0002,
   parameter logic [15:0] RD_CYC = 16'h0003,
   parameter logic [15:0] SETTLE_CYC = 16'h0004
) (
   input wire logic clk, // System clock
   input wire logic reset_n, // Synchronous reset, active low
   input wire logic pd_req, // Hold device in deep power-down
   input wire logic vpp_ok, // Programming supply above lockout
   input wire logic cmd_valid, // Request present
   input wire logic [2:0] cmd_op, // Request kind
   input wire logic [19:0] cmd_addr, // Byte address
   input wire logic [7:0] cmd_data, // Byte to program
   output logic cmd_ready, // Request may be taken
   output logic rsp_valid, // Answer pulse
   output logic rsp_err, // Request refused
   output logic [7:0] rsp_data, // Read byte or status
   output logic erase_active, // Block erase outstanding
   output logic erase_suspended, // Erase held in suspend
   output logic [19:0] flash_addr, // Address pins
   output logic [7:0] flash_dq_out, // Data pins, driven value
   output logic flash_dq_oe, // Data pins driven
   input wire logic [7:0] flash_dq_in, // Data pins, sensed value
   output logic flash_ce_n, // Chip select
   output logic flash_oe_n, // Output enable
   output logic flash_we_n, // Write strobe
   output logic powerdown_reset_n, // Power-down and reset
   input wire logic ready_busy_out // Device ready, low when busy
);
   fcc_tmr_if tif ();
   fcc_timer u_timer (.clk(clk), .reset_n(reset_n), .t(tif));

   fcc_pkg::fcc_state_t state, next_state;
   fcc_pkg::fcc_op_t op;
   logic idx, next_idx;
   logic [19:0] op_addr;
   logic [7:0] op_data;
   logic [3:0] erase_blk;
   logic next_erase, next_susp, next_rsp_valid, next_rsp_err, take;
   logic [7:0] next_rsp_data;

   wire fcc_pkg::fcc_op_t req_op = fcc_pkg::fcc_op_t'(cmd_op);
   wire req_alters = (req_op == fcc_pkg::FCC_OP_WRITE) || (req_op == fcc_pkg::FCC_OP_ERASE)
      || (req_op == fcc_pkg::FCC_OP_RESUME);
   wire [3:0] req_blk = cmd_addr[19:16];
   wire running = erase_active && !erase_suspended;
   // R18: alterations refused when supply is low
   wire refuse_vpp = req_alters && !vpp_ok;
   // R04: no reads from the block under erase
   wire refuse_blk = (req_op == fcc_pkg::FCC_OP_READ) && erase_active
      && req_blk == erase_blk;
   wire refuse_busy = (req_op == fcc_pkg::FCC_OP_WRITE || req_op == fcc_pkg::FCC_OP_ERASE
      || req_op == fcc_pkg::FCC_OP_READ) && running;
   wire refuse_state = (req_op == fcc_pkg::FCC_OP_ERASE && erase_active)
      || (req_op == fcc_pkg::FCC_OP_WRITE && erase_active)
      || (req_op == fcc_pkg::FCC_OP_SUSPEND && !running)
      || (req_op == fcc_pkg::FCC_OP_RESUME && !erase_suspended)
      || (cmd_op > 3'h6);
   wire refuse = refuse_vpp || refuse_blk || refuse_busy || refuse_state;
   // R05: two-write operations
   wire two_writes = (op == fcc_pkg::FCC_OP_WRITE) || (op == fcc_pkg::FCC_OP_ERASE);
   wire [7:0] first_code =
      (op == fcc_pkg::FCC_OP_READ) ? CMD_READ_ARRAY :
      (op == fcc_pkg::FCC_OP_WRITE) ? CMD_WRITE_SETUP :
      (op == fcc_pkg::FCC_OP_ERASE) ? CMD_ERASE_SETUP :
      (op == fcc_pkg::FCC_OP_SUSPEND) ? CMD_SUSPEND :
      (op == fcc_pkg::FCC_OP_RESUME) ? CMD_RESUME :
      (op == fcc_pkg::FCC_OP_STATUS) ? CMD_READ_STATUS : CMD_CLEAR_STATUS;
   wire [7:0] second_code = (op == fcc_pkg::FCC_OP_ERASE) ? CMD_ERASE_CONFIRM : op_data;
   wire [7:0] next_dq = next_idx ? second_code : first_code;
   wire ns_wlo = next_state == fcc_pkg::FCC_ST_WLO;
   wire ns_whi = next_state == fcc_pkg::FCC_ST_WHI;
   wire ns_rd = next_state == fcc_pkg::FCC_ST_RD;

   always_comb begin
      next_state = state;
      next_idx = idx;
      next_erase = erase_active;
      next_susp = erase_suspended;
      next_rsp_valid = 1'b0;
      next_rsp_err = 1'b0;
      next_rsp_data = rsp_data;
      take = 1'b0;
      tif.load = 1'b0;
      tif.count = '0;
      if (pd_req && state != fcc_pkg::FCC_ST_PD) begin
         // R15: power-down aborts the operation under way
         next_state = fcc_pkg::FCC_ST_PD;
         next_erase = 1'b0;
         next_susp = 1'b0;
      end else begin
         unique case (state)
            fcc_pkg::FCC_ST_PD: begin
               if (!pd_req) begin
                  // R13: wake delay covers read recovery
                  // R14: and the command-write wake time
                  next_state = fcc_pkg::FCC_ST_WAKE;
                  tif.load = 1'b1;
                  tif.count = fcc_pkg::WAKE_CYC;
               end
            end
            fcc_pkg::FCC_ST_WAKE: begin
               if (tif.done) begin
                  // R16: wake lands in read-array idle
                  next_state = fcc_pkg::FCC_ST_IDLE;
               end
            end
            fcc_pkg::FCC_ST_IDLE: begin
               // R03: erase ends once the device reports ready
               // R10: suspended erase also shows ready
               if (running && tif.done && ready_busy_out) begin
                  next_erase = 1'b0;
               end
               if (cmd_valid && refuse) begin
                  next_rsp_valid = 1'b1;
                  next_rsp_err = 1'b1;
               end else if (cmd_valid) begin
                  take = 1'b1;
                  next_idx = 1'b0;
                  next_state = fcc_pkg::FCC_ST_WLO;
                  tif.load = 1'b1;
                  tif.count = WE_CYC;
               end
            end
            fcc_pkg::FCC_ST_WLO: begin
               if (tif.done) begin
                  next_state = fcc_pkg::FCC_ST_WHI;
               end
            end
            fcc_pkg::FCC_ST_WHI: begin
               tif.load = 1'b1;
               if (!idx && two_writes) begin
                  // R05: confirm write follows the setup at once
                  next_idx = 1'b1;
                  next_state = fcc_pkg::FCC_ST_WLO;
                  tif.count = WE_CYC;
               end else if (op == fcc_pkg::FCC_OP_READ || op == fcc_pkg::FCC_OP_STATUS) begin
                  next_state = fcc_pkg::FCC_ST_RD;
                  tif.count = RD_CYC;
               end else if (op == fcc_pkg::FCC_OP_WRITE || op == fcc_pkg::FCC_OP_SUSPEND) begin
                  next_state = fcc_pkg::FCC_ST_SETTLE;
                  tif.count = SETTLE_CYC;
               end else begin
                  // R02: erase runs in the background
                  next_state = fcc_pkg::FCC_ST_IDLE;
                  tif.count = SETTLE_CYC;
                  next_rsp_valid = 1'b1;
                  if (op == fcc_pkg::FCC_OP_ERASE) begin
                     next_erase = 1'b1;
                  end
                  if (op == fcc_pkg::FCC_OP_RESUME) begin
                     next_susp = 1'b0;
                  end
               end
            end
            fcc_pkg::FCC_ST_RD: begin
               if (tif.done) begin
                  // R08: status or array byte returned
                  next_rsp_data = flash_dq_in;
                  next_rsp_valid = 1'b1;
                  next_state = fcc_pkg::FCC_ST_IDLE;
               end
            end
            fcc_pkg::FCC_ST_SETTLE: begin
               if (tif.done) begin
                  next_state = fcc_pkg::FCC_ST_BUSY;
               end
            end
            fcc_pkg::FCC_ST_BUSY: begin
               // R06: host only waits for the device to finish
               // R09: low ready/busy holds the host here
               if (ready_busy_out) begin
                  next_rsp_valid = 1'b1;
                  next_state = fcc_pkg::FCC_ST_IDLE;
                  if (op == fcc_pkg::FCC_OP_SUSPEND) begin
                     next_susp = 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= fcc_pkg::FCC_ST_PD;
         op <= fcc_pkg::FCC_OP_READ;
         op_addr <= '0;
         op_data <= '0;
         erase_blk <= '0;
         idx <= 1'b0;
         erase_active <= 1'b0;
         erase_suspended <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_err <= 1'b0;
         rsp_data <= '0;
         cmd_ready <= 1'b0;
      end else begin
         state <= next_state;
         idx <= next_idx;
         erase_active <= next_erase;
         erase_suspended <= next_susp;
         rsp_valid <= next_rsp_valid;
         rsp_err <= next_rsp_err;
         rsp_data <= next_rsp_data;
         cmd_ready <= next_state == fcc_pkg::FCC_ST_IDLE && !take;
         if (take) begin
            op <= req_op;
            // R07: one byte per write
            op_data <= cmd_data;
            // R01: full byte address kept for the cycle, block base only for erase
            op_addr <= (req_op == fcc_pkg::FCC_OP_ERASE) ? {req_blk, 16'h0000} : cmd_addr;
            if (req_op == fcc_pkg::FCC_OP_ERASE) begin
               erase_blk <= req_blk;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         flash_addr <= '0;
         flash_dq_out <= '0;
         flash_dq_oe <= 1'b0;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         powerdown_reset_n <= 1'b0;
      end else begin
         flash_addr <= take ? ((req_op == fcc_pkg::FCC_OP_ERASE) ? {req_blk, 16'h0000}
            : cmd_addr) : op_addr;
         flash_dq_out <= take ? CMD_READ_ARRAY : next_dq;
         flash_dq_oe <= ns_wlo || ns_whi;
         // R11: chip select released between operations for standby
         flash_ce_n <= !(ns_wlo || ns_whi || ns_rd);
         flash_oe_n <= !ns_rd;
         // R17: strobe rises with address and data still held
         flash_we_n <= !ns_wlo;
         // R12: power-down held low while requested
         powerdown_reset_n <= next_state != fcc_pkg::FCC_ST_PD;
      end
   end
endmodule
`default_nettype wire

// *** fcc_pkg.sv ***
package fcc_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned TMR_W = 16;
   // Read-data recovery after power-down release, in ns
   localparam int unsigned PD_READ_NS = 400;
   // Command-write wake time after power-down release, in ns
   localparam int unsigned PD_WRITE_NS = 1000;
   localparam logic [TMR_W-1:0] PD_READ_CYC =
      TMR_W'((PD_READ_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
   localparam logic [TMR_W-1:0] PD_WRITE_CYC =
      TMR_W'((PD_WRITE_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
   localparam logic [TMR_W-1:0] WAKE_CYC =
      (PD_WRITE_CYC > PD_READ_CYC) ? PD_WRITE_CYC : PD_READ_CYC;
   localparam int unsigned ADDR_W = 20;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned BLK_W = 4;
   localparam int unsigned BLK_OFS_W = 16;

   typedef enum logic [2:0] {
      FCC_OP_READ = 3'h0,
      FCC_OP_WRITE = 3'h1,
      FCC_OP_ERASE = 3'h2,
      FCC_OP_SUSPEND = 3'h3,
      FCC_OP_RESUME = 3'h4,
      FCC_OP_STATUS = 3'h5,
      FCC_OP_CLEAR = 3'h6
   } fcc_op_t;

   typedef enum logic [2:0] {
      FCC_ST_PD = 3'h0,
      FCC_ST_WAKE = 3'h1,
      FCC_ST_IDLE = 3'h2,
      FCC_ST_WLO = 3'h3,
      FCC_ST_WHI = 3'h4,
      FCC_ST_RD = 3'h5,
      FCC_ST_SETTLE = 3'h6,
      FCC_ST_BUSY = 3'h7
   } fcc_state_t;
endpackage

// *** fcc_tmr_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface fcc_tmr_if;
   logic load;
   logic [fcc_pkg::TMR_W-1:0] count;
   logic done;
   modport owner (output load, output count, input done);
   modport timer (input load, input count, output done);
endinterface
`default_nettype wire

// *** fcc_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcc_timer (
   input wire logic clk, // System clock
   input wire logic reset_n, // Synchronous reset, active low
   fcc_tmr_if.timer t // Load and done handshake
);
   logic [fcc_pkg::TMR_W-1:0] remain;
   logic [fcc_pkg::TMR_W-1:0] next_remain;

   assign next_remain = t.load ? t.count :
      (remain != '0) ? remain - fcc_pkg::TMR_W'(1) : remain;
   assign t.done = (remain == '0) && !t.load;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         remain <= '0;
      end else begin
         remain <= next_remain;
      end
   end
endmodule
`default_nettype wire

// *** fcc_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcc_flash_model #(
   parameter int WR_CYC = 180,
   parameter int ER_CYC = 400
) (
   input wire logic clk, // Model time base
   input wire logic [19:0] a, // Address pins
   input wire logic [7:0] d, // Data pins, bus level
   input wire logic ce_n, // Chip select
   input wire logic oe_n, // Output enable
   input wire logic we_n, // Write strobe
   input wire logic rp_n, // Power-down
   output logic [7:0] q, // Data pins, model drive
   output logic ry // Ready, low when busy
);
   bit [7:0] mem [0:1048575];
   logic [7:0] pend = 8'h00;
   logic [7:0] prev = 8'h00;
   logic rd_sr = 1'b0;
   logic susp = 1'b0;
   logic ers = 1'b0;
   logic [3:0] blk = 4'h0;
   int busy = 0;
   int wake = 0;
   wire logic drv = !ce_n && !oe_n && rp_n;
   wire logic [7:0] val = rd_sr ? {ry, susp, 6'h00} : mem[a];
   // busy unless suspended or powered down
   assign ry = !rp_n || susp || busy == 0;
   // undriven or unrecovered pins show a changing pattern
   assign q = (drv && wake <= 12) ? val : ~prev;
   initial foreach (mem[i]) mem[i] = 8'hFF;
   // Self-timing steps on the falling edge so the busy and wake countdowns never end at the host's edge
   always @(negedge clk) begin
      prev = q;
      // power-down aborts and returns to array reads
      if (!rp_n) begin
         busy = 0;
         susp = 0;
         ers = 0;
         rd_sr = 0;
         pend = 8'h00;
         wake = 20;
      end else begin
         if (wake > 0) wake--;
         // self-timed, erase touches one block only
         if (busy > 0 && !susp) begin
            busy--;
            if (busy == 0 && ers) begin
               ers = 0;
               for (int i = 0; i < 65536; i++) mem[{blk, i[15:0]}] = 8'hFF;
            end
         end
      end
   end
   // latch on strobe rise once awake; codes follow host defaults
   always @(posedge we_n) if (!ce_n && rp_n && wake == 0) begin
      if (pend == 8'h08) begin
         mem[a] = d;
         busy = WR_CYC;
         rd_sr = 1;
         pend = 8'h00;
      end else if (pend == 8'h04) begin
         pend = 8'h00;
         if (d == 8'h05) begin
            blk = a[19:16];
            ers = 1;
            busy = ER_CYC;
            rd_sr = 1;
         end
      end else case (d)
         8'h01: rd_sr = 0;
         8'h02: rd_sr = 1;
         8'h03: pend = 8'h00;
         8'h06: if (ers) begin
            susp = 1;
            rd_sr = 1;
         end
         8'h07: susp = 0;
         default: pend = d;
      endcase
   end
endmodule
`default_nettype wire

// *** fcc_host_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcc_host_chk (
   input wire logic clk, // Clock
   input wire logic reset_n, // Reset
   input wire logic pd_req, // Power-down request
   input wire logic vpp_ok, // Supply ok
   input wire logic cmd_valid, // Request
   input wire logic [2:0] cmd_op, // Kind
   input wire logic cmd_ready, // Idle
   input wire logic rsp_valid, // Answer
   input wire logic rsp_err, // Refused
   input wire logic erase_active, // Erase pending
   input wire logic [19:0] flash_addr, // Address
   input wire logic [7:0] flash_dq_out, // Data
   input wire logic flash_dq_oe, // Data driven
   input wire logic flash_ce_n, // Select
   input wire logic flash_oe_n, // Output enable
   input wire logic flash_we_n, // Strobe
   input wire logic powerdown_reset_n // Power-down
);
   logic [4:0] wake_cnt;
   wire logic take = cmd_valid && cmd_ready;
   always_ff @(posedge clk) begin
      if (!powerdown_reset_n) wake_cnt <= 5'h00;
      else if (wake_cnt != 5'h1F) wake_cnt <= wake_cnt + 5'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_setup;
      !flash_we_n [*3] ##1 flash_we_n;
   endsequence
   sequence s_confirm;
      !flash_we_n [*3] ##1 flash_we_n;
   endsequence
   a_pd_idle: assert property (pd_req |=> !powerdown_reset_n && flash_ce_n && flash_we_n)
      else $error("pins not idle in power-down");
   a_pd_abort: assert property (pd_req |=> !erase_active)
      else $error("erase survives power-down");
   a_wake_gap: assert property (!flash_we_n |-> wake_cnt >= 5'h14)
      else $error("write too soon after wake");
   a_write_pair: assert property (take && cmd_op == 3'h1 && vpp_ok && !erase_active |=>
      s_setup ##1 s_confirm) else $error("write cycles not back to back");
   a_latch_hold: assert property ($rose(flash_we_n) |->
      $stable(flash_addr) && $stable(flash_dq_out) && flash_dq_oe) else $error("bus moved at latch");
   a_vpp_refuse: assert property (take && !vpp_ok && cmd_op inside {3'h1, 3'h2, 3'h4} |=>
      rsp_valid && rsp_err) else $error("low supply not refused");
   a_susp_refuse: assert property (take && cmd_op == 3'h3 && !erase_active |=> rsp_err)
      else $error("suspend without erase taken");
   a_no_contend: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe)
      else $error("read with data driven");
   a_idle_pins: assert property (cmd_ready |-> flash_ce_n && flash_we_n && powerdown_reset_n)
      else $error("idle without standby");
endmodule
bind fcc_host fcc_host_chk u_chk (.clk(clk), .reset_n(reset_n), .pd_req(pd_req),
   .vpp_ok(vpp_ok), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready),
   .rsp_valid(rsp_valid), .rsp_err(rsp_err), .erase_active(erase_active),
   .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
   .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
   .powerdown_reset_n(powerdown_reset_n));
`default_nettype wire

// *** fcc_host_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcc_host_tb;
   logic clk = 0, reset_n = 0, pd_req = 0, vpp_ok = 1, cmd_valid = 0;
   logic [2:0] cmd_op = 3'h0;
   logic [19:0] cmd_addr = 20'h00000;
   logic [7:0] cmd_data = 8'h00;
   logic r_err;
   logic [7:0] r_data;
   int err_total = 0, total_checks = 0, cyc = 0;
   wire logic cmd_ready, rsp_valid, rsp_err, erase_active, erase_suspended;
   wire logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, powerdown_reset_n, ready_busy_out;
   wire logic [7:0] rsp_data, flash_dq_out, dq_mod, dq_bus;
   wire logic [19:0] flash_addr;
   assign dq_bus = flash_dq_oe ? flash_dq_out : dq_mod;
   always #25 clk = ~clk;
   fcc_host dut (.clk(clk), .reset_n(reset_n), .pd_req(pd_req), .vpp_ok(vpp_ok),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data),
      .erase_active(erase_active), .erase_suspended(erase_suspended),
      .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
      .flash_dq_in(dq_bus), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n), .powerdown_reset_n(powerdown_reset_n),
      .ready_busy_out(ready_busy_out));
   fcc_flash_model flash (.clk(clk), .a(flash_addr), .d(dq_bus), .ce_n(flash_ce_n),
      .oe_n(flash_oe_n), .we_n(flash_we_n), .rp_n(powerdown_reset_n), .q(dq_mod),
      .ry(ready_busy_out));
   task summarize;
      if (err_total == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task req(input logic [2:0] op, input logic [19:0] ad, input logic [7:0] da);
      int n;
      n = 0;
      do @(negedge clk); while (!cmd_ready);
      cmd_op = op;
      cmd_addr = ad;
      cmd_data = da;
      cmd_valid = 1;
      @(negedge clk);
      cmd_valid = 0;
      while (rsp_valid !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000) chk("response", 8'h00, 8'h01);
      r_err = rsp_err;
      r_data = rsp_data;
   endtask
   task rd(input logic [19:0] ad, input logic [7:0] e);
      req(3'h0, ad, 8'h00);
      chk("read data", r_data, e);
   endtask
   task t_wake;
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk("wake time", {7'h00, n >= 20 && cmd_ready === 1'b1}, 8'h01);
   endtask
   task t_write;
      req(3'h1, 20'hFFFFF, 8'hA5);
      chk("write err", {7'h00, r_err}, 8'h00);
      req(3'h1, 20'h00000, 8'h5A);
      rd(20'hFFFFF, 8'hA5);
      rd(20'h00000, 8'h5A);
      req(3'h5, 20'h00000, 8'h00);
      chk("status", r_data, 8'h80);
      req(3'h6, 20'h00000, 8'h00);
      chk("clear status", {7'h00, r_err}, 8'h00);
      req(3'h5, 20'h00000, 8'h00);
      chk("status cleared", r_data, 8'h80);
      chk("standby", {7'h00, flash_ce_n}, 8'h01);
   endtask
   task t_refuse;
      vpp_ok = 0;
      req(3'h1, 20'h00010, 8'h11);
      chk("low supply", {7'h00, r_err}, 8'h01);
      vpp_ok = 1;
      rd(20'h00010, 8'hFF);
      req(3'h3, 20'h00000, 8'h00);
      chk("stray suspend", {7'h00, r_err}, 8'h01);
      req(3'h7, 20'h00000, 8'h00);
      chk("bad op", {7'h00, r_err}, 8'h01);
   endtask
   task t_erase;
      int n;
      req(3'h1, 20'h10004, 8'h3C);
      req(3'h1, 20'h20004, 8'hC3);
      req(3'h2, 20'h1ABCD, 8'h00);
      chk("busy line", {7'h00, ready_busy_out}, 8'h00);
      req(3'h0, 20'h20004, 8'h00);
      chk("read in erase", {7'h00, r_err}, 8'h01);
      req(3'h3, 20'h00000, 8'h00);
      chk("suspended", {6'h00, erase_suspended, ready_busy_out}, 8'h03);
      rd(20'h20004, 8'hC3);
      req(3'h0, 20'h10004, 8'h00);
      chk("read erasing blk", {7'h00, r_err}, 8'h01);
      req(3'h4, 20'h00000, 8'h00);
      n = 0;
      while (erase_active !== 1'b0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      rd(20'h10004, 8'hFF);
      rd(20'h20004, 8'hC3);
   endtask
   task t_pd;
      req(3'h2, 20'h20000, 8'h00);
      pd_req = 1;
      repeat (3) @(negedge clk);
      chk("pd pins", {6'h00, powerdown_reset_n, erase_active}, 8'h00);
      pd_req = 0;
      t_wake;
      req(3'h5, 20'h00000, 8'h00);
      chk("status after pd", r_data, 8'h80);
      rd(20'h20004, 8'hC3);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         summarize;
      end
   end
   initial begin
      repeat (20) @(negedge clk);
      reset_n = 1;
      t_wake;
      t_write;
      t_refuse;
      t_erase;
      t_pd;
      summarize;
   end
endmodule
`default_nettype wire
